// >>> common/sipo_driver_pkg.sv
// shared constants and carrier types for the serial-in latched driver
// assumes one system clock; the serial clock, data, strobe and enable arrive as pins
package sipo_driver_pkg;
    localparam int          STAGES      = 8;
    localparam int          FIFO_DEPTH  = 32;
    localparam int          SYNC_STAGES = 2;
    localparam logic [7:0]  STAGE_INIT  = 8'h00;
    localparam logic        OUT_OFF     = 1'b0;

    // pin-side inputs after synchronisation
    typedef struct packed {
        logic ser_clk;
        logic ser_in;
        logic strobe;
        logic enable;
    } pins_s;

    // driver-side outputs
    typedef struct packed {
        logic [STAGES-1:0] drive;
        logic              ser_out;
    } outs_s;
endpackage : sipo_driver_pkg

// >>> design/word_fifo.sv
// parameterised synchronous FIFO with valid/ready on both sides
// assumes a single clock and asynchronous active-low reset
module word_fifo
    import sipo_driver_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             sys_clk,
    input  wire logic             resetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0]   count;
    } fifo_state_s;

    fifo_state_s      st_reg;
    fifo_state_s      st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    always_comb begin
        in_ready  = (st_reg.count != (AW+1)'(DEPTH));
        out_valid = (st_reg.count != '0);
        out_data  = mem[st_reg.rd_ptr];
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        st_next   = st_reg;
        if (push) begin
            st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : st_reg.wr_ptr + 1'b1;
        end
        if (pop) begin
            st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : st_reg.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            st_next.count = st_reg.count + 1'b1;
        end else if (pop && !push) begin
            st_next.count = st_reg.count - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // storage has no reset; only written on push
    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[st_reg.wr_ptr] <= in_data;
        end
    end
endmodule : word_fifo

// >>> design/serial_in_latched_driver.sv
// serial-in shift register, transparent latch bank and gated output drivers
// assumes pins are asynchronous to sys_clk and the serial clock is far slower
//
// Behaviour
// - eight shift stages, eight latches, eight outputs, one of each per stage.
// - rising serial clock captures serial input into stage one; otherwise hold.
// - each rising edge moves every stage one place toward serial output.
// - serial output shows the eighth stage for cascading.
// - strobe high copies stages into latches; strobe low holds latches.
// - latches stay transparent while strobe high, following register changes.
// - enable high forces every drive output off; serial output and stored state untouched.
// - enable low drives each output from its latch.
module serial_in_latched_driver
    import sipo_driver_pkg::*;
#(
    parameter int N_STAGES = STAGES
) (
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    input  wire logic                ser_clk_pin,
    input  wire logic                ser_in_pin,
    input  wire logic                strobe_pin,
    input  wire logic                enable_pin,
    output logic                     ser_out,
    output logic [N_STAGES-1:0]      drive,
    output logic                     shift_ready,
    output logic                     contents_valid
);
    // the fifo holds captured serial bits between edge detection and the shifter
    typedef struct packed {
        logic [SYNC_STAGES-1:0] clk_sync;
        logic [SYNC_STAGES-1:0] din_sync;
        logic [SYNC_STAGES-1:0] stb_sync;
        logic [SYNC_STAGES-1:0] en_sync;
        logic                   clk_prev;
        logic [N_STAGES-1:0]    shift;
        logic [N_STAGES-1:0]    latch;
        logic [3:0]             shifted;
        logic                   known;
        outs_s                  outs;
    } drv_state_s;

    drv_state_s          st_reg;
    drv_state_s          st_next;
    pins_s               pins;
    logic                rise;
    logic                fifo_in_ready;
    logic                fifo_out_valid;
    logic                fifo_out_data;
    logic                take_bit;
    logic [N_STAGES-1:0] shift_new;

    function automatic logic [N_STAGES-1:0] shift_one(input logic [N_STAGES-1:0] s,
                                                       input logic d);
        shift_one = {s[N_STAGES-2:0], d};
    endfunction : shift_one

    // only the second synchroniser flop is read
    always_comb begin
        pins.ser_clk = st_reg.clk_sync[SYNC_STAGES-1];
        pins.ser_in  = st_reg.din_sync[SYNC_STAGES-1];
        pins.strobe  = st_reg.stb_sync[SYNC_STAGES-1];
        pins.enable  = st_reg.en_sync[SYNC_STAGES-1];
    end

    assign rise = pins.ser_clk && !st_reg.clk_prev;

    word_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_bit_fifo (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .in_valid  (rise),
        .in_ready  (fifo_in_ready),
        .in_data   (pins.ser_in),
        .out_valid (fifo_out_valid),
        .out_ready (1'b1),
        .out_data  (fifo_out_data)
    );

    assign take_bit = fifo_out_valid;

    always_comb begin
        st_next          = st_reg;
        st_next.clk_sync = {st_reg.clk_sync[SYNC_STAGES-2:0], ser_clk_pin};
        st_next.din_sync = {st_reg.din_sync[SYNC_STAGES-2:0], ser_in_pin};
        st_next.stb_sync = {st_reg.stb_sync[SYNC_STAGES-2:0], strobe_pin};
        st_next.en_sync  = {st_reg.en_sync[SYNC_STAGES-2:0], enable_pin};
        st_next.clk_prev = pins.ser_clk;

        shift_new = st_reg.shift;
        if (take_bit) begin
            shift_new = shift_one(st_reg.shift, fifo_out_data);
            if (st_reg.shifted != 4'(N_STAGES)) begin
                st_next.shifted = st_reg.shifted + 1'b1;
            end
        end
        st_next.shift = shift_new;

        // transparent: follows the register in the same cycle it changes
        if (pins.strobe) begin
            st_next.latch = shift_new;
            if (st_next.shifted == 4'(N_STAGES)) begin
                st_next.known = 1'b1;
            end
        end

        st_next.outs.ser_out = shift_new[N_STAGES-1];
        if (pins.enable) begin
            st_next.outs.drive = {N_STAGES{OUT_OFF}};
        end else begin
            st_next.outs.drive = st_next.latch;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_reg         <= '0;
            st_reg.en_sync <= '1;
            st_reg.outs    <= '0;
            st_reg.shift   <= N_STAGES'(STAGE_INIT);
            st_reg.latch   <= N_STAGES'(STAGE_INIT);
        end else begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        ser_out        = st_reg.outs.ser_out;
        drive          = st_reg.outs.drive;
        contents_valid = st_reg.known;
        shift_ready    = fifo_in_ready;
    end
endmodule : serial_in_latched_driver

// >>> sim/serial_in_latched_driver_properties.sv
// checker on the driver's ports: shifting, latching and output gating
// assumes pins are driven in step with sys_clk by a slow host
module driver_props
    import sipo_driver_pkg::*;
#(
    parameter int N_STAGES = STAGES
) (
    input wire logic                sys_clk,
    input wire logic                resetn,
    input wire logic                ser_clk_pin,
    input wire logic                ser_in_pin,
    input wire logic                strobe_pin,
    input wire logic                enable_pin,
    input wire logic                ser_out,
    input wire logic [N_STAGES-1:0] drive,
    input wire logic                shift_ready,
    input wire logic                contents_valid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence open_s; (strobe_pin && !enable_pin)[*8]; endsequence
    sequence closed_s; (!enable_pin && !strobe_pin); endsequence
    sequence pulse_s; closed_s[*6] ##1 (enable_pin && !strobe_pin)[*8] ##1 closed_s[*5];
    endsequence
    outputs_off_a: assert property (enable_pin[*5] |-> drive == '0)
        else $error("outputs on while disabled");
    latch_hold_a: assert property (closed_s[*5] |=> $stable(drive))
        else $error("latch changed with strobe low");
    no_edge_a: assert property ($stable(ser_clk_pin)[*7] |=> $stable(ser_out))
        else $error("serial output moved without clock edge");
    tail_stage_a: assert property (open_s |-> drive[N_STAGES-1] == ser_out)
        else $error("serial output differs from last stage");
    shift_step_a: assert property (open_s ##0 $rose(ser_clk_pin) |-> ##6
        drive == {$past(drive[N_STAGES-2:0], 6), $past(ser_in_pin, 6)})
        else $error("shift step wrong");
    state_kept_a: assert property (pulse_s |-> drive == $past(drive, 13))
        else $error("disable pulse altered stored state");
    valid_sticky_a: assert property (contents_valid |=> contents_valid)
        else $error("contents valid dropped");
    ready_high_a: assert property (shift_ready)
        else $error("bit queue full under slow host");
endmodule : driver_props
bind serial_in_latched_driver driver_props #(.N_STAGES(N_STAGES)) props (
    .sys_clk(sys_clk), .resetn(resetn), .ser_clk_pin(ser_clk_pin),
    .ser_in_pin(ser_in_pin), .strobe_pin(strobe_pin), .enable_pin(enable_pin),
    .ser_out(ser_out), .drive(drive), .shift_ready(shift_ready),
    .contents_valid(contents_valid));

// >>> sim/host_model.sv
// host that shifts bytes msb first and sets strobe and enable
// assumes sys_clk is the bench clock; serial clock rests low between bytes
module host_model (
    input  wire logic sys_clk,
    output logic      ser_clk_pin,
    output logic      ser_in_pin,
    output logic      strobe_pin,
    output logic      enable_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ser_clk_pin = 1'b0;
        ser_in_pin = 1'b0;
        strobe_pin = 1'b0;
        enable_pin = 1'b1;
    end
    task step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step
    task set_ctl(input logic s, input logic e);
        strobe_pin = s;
        enable_pin = e;
    endtask : set_ctl
    task send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            ser_in_pin = b[i];
            step(4);
            ser_clk_pin = 1'b1;
            step(4);
            ser_clk_pin = 1'b0;
            step(2);
            ser_in_pin = ~b[i];
            step(2);
        end
    endtask : send_byte
endmodule : host_model

// >>> sim/tb_serial_in_latched_driver.sv
// self-checking bench: load, hold, disable, transparent and bypass use
// assumes the host model paces all pins
module tb_serial_in_latched_driver;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk, resetn, ser_clk_pin, ser_in_pin, strobe_pin, enable_pin;
    logic       ser_out, shift_ready, contents_valid;
    logic [7:0] drive;
    int         n_mismatch = 0;
    int         checks = 0;
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    host_model host (.sys_clk(sys_clk), .ser_clk_pin(ser_clk_pin), .ser_in_pin(ser_in_pin),
        .strobe_pin(strobe_pin), .enable_pin(enable_pin));
    serial_in_latched_driver uut (.sys_clk(sys_clk), .resetn(resetn),
        .ser_clk_pin(ser_clk_pin), .ser_in_pin(ser_in_pin), .strobe_pin(strobe_pin),
        .enable_pin(enable_pin), .ser_out(ser_out), .drive(drive),
        .shift_ready(shift_ready), .contents_valid(contents_valid));
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task report_and_stop;
        if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task t_load;
        host.send_byte(8'ha5);
        chk("drive_off", 8'h00, drive);
        host.set_ctl(1'b1, 1'b1);
        host.step(4);
        host.set_ctl(1'b0, 1'b0);
        host.step(6);
        chk("drive_load", 8'ha5, drive);
        chk("flags", 8'h03, {6'h0, ser_out, contents_valid});
    endtask : t_load
    task t_hold;
        host.send_byte(8'h3c);
        host.step(2);
        chk("drive_hold", 8'ha5, drive);
        chk("ser_out", 8'h00, {7'h0, ser_out});
        host.set_ctl(1'b0, 1'b1);
        host.step(8);
        chk("drive_off", 8'h00, drive);
        host.set_ctl(1'b0, 1'b0);
        host.step(6);
        chk("drive_kept", 8'ha5, drive);
    endtask : t_hold
    task t_follow;
        host.set_ctl(1'b1, 1'b0);
        host.step(10);
        chk("drive_open", 8'h3c, drive);
        host.send_byte(8'hc3);
        host.step(4);
        chk("drive_follow", 8'hc3, drive);
        chk("ready", 8'h01, {7'h0, shift_ready});
    endtask : t_follow
    task t_bypass;
        host.set_ctl(1'b1, 1'b1);
        host.send_byte(8'h5a);
        chk("bypass_off", 8'h00, drive);
        host.set_ctl(1'b1, 1'b0);
        host.step(6);
        chk("bypass_on", 8'h5a, drive);
        host.set_ctl(1'b0, 1'b0);
    endtask : t_bypass
    initial begin
        resetn = 1'b0;
        host.step(2);
        chk("reset_drive", 8'h00, drive);
        chk("reset_flags", 8'h01, {5'h0, ser_out, contents_valid, shift_ready});
        resetn = 1'b1;
        host.step(4);
        t_load();
        t_hold();
        t_follow();
        t_bypass();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_serial_in_latched_driver
